// file: pkg/branch_pkg.sv
// Constants and types for the conditional relative-branch evaluator.
// Assumes a core clock of 200 MHz and flags supplied by the core.
package branch_pkg;

   localparam int PC_WIDTH_DEF  = 16;
   localparam int OFS_WIDTH_DEF = 7;

   // Branch condition selector
   typedef enum logic [2:0] {
      COND_SIGNED_LESS          = 3'h0,
      COND_SIGNED_GREATER_EQUAL = 3'h1,
      COND_NIBBLE_CARRY_SET     = 3'h2,
      COND_NIBBLE_CARRY_CLEAR   = 3'h3,
      COND_COPY_FLAG_SET        = 3'h4,
      COND_COPY_FLAG_CLEAR      = 3'h5,
      COND_SIGNED_WRAP_SET      = 3'h6
   } cond_t;

   // Status flag bit positions in the flag byte
   localparam int FLAG_SIGN_POS   = 2;
   localparam int FLAG_WRAP_POS   = 3;
   localparam int FLAG_NIBBLE_POS = 5;
   localparam int FLAG_COPY_POS   = 6;

   localparam logic [7:0] FLAGS_RST = 8'h00;

   // Cycle counts
   localparam int CYC_NOT_TAKEN = 1;
   localparam int CYC_TAKEN     = 2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_TAKEN = 2'b10
   } state_t;

endpackage : branch_pkg

// file: pkg/flag_if.sv
// Carries flag byte and condition select to the evaluator.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
interface flag_if;
   import branch_pkg::*;
   logic [7:0] flags;
   cond_t      cond;
   logic       taken;
   modport core (output flags, output cond, input taken);
   modport eval (input flags, input cond, output taken);
endinterface : flag_if

// file: hdl/cond_eval.sv
// Combinational condition evaluator for relative branches.
// Assumes flags are stable in the decode cycle.
`timescale 1ns/10ps
module cond_eval (
   flag_if.eval fi
);
   import branch_pkg::*;

   function automatic logic flag_bit(input logic [7:0] f, input int pos);
      return f[pos];
   endfunction : flag_bit

   always_comb begin
      logic n;
      logic v;
      logic h;
      logic t;
      n = flag_bit(fi.flags, FLAG_SIGN_POS);
      v = flag_bit(fi.flags, FLAG_WRAP_POS);
      h = flag_bit(fi.flags, FLAG_NIBBLE_POS);
      t = flag_bit(fi.flags, FLAG_COPY_POS);
      case (fi.cond)
         // [RL1] Sign xor wrap
         COND_SIGNED_LESS:          fi.taken = n ^ v;
         // [RL2] Sign xnor wrap
         COND_SIGNED_GREATER_EQUAL: fi.taken = ~(n ^ v);
         // [RL3] Nibble carry set
         COND_NIBBLE_CARRY_SET:     fi.taken = h;
         // [RL4] Nibble carry clear
         COND_NIBBLE_CARRY_CLEAR:   fi.taken = ~h;
         // [RL5] Copy flag set
         COND_COPY_FLAG_SET:        fi.taken = t;
         // [RL6] Copy flag clear
         COND_COPY_FLAG_CLEAR:      fi.taken = ~t;
         // [RL7] Wrap flag set
         COND_SIGNED_WRAP_SET:      fi.taken = v;
         default:                   fi.taken = 1'b0;
      endcase
   end

endmodule : cond_eval

// file: hdl/cond_branch_flag_eval.sv
// Conditional relative-branch unit: evaluates flags, updates PC.
// Assumes the core presents one branch per START pulse, flags valid then.
// What this block does
// [RL1] Signed less: jump when sign xor wrap
// [RL2] Signed greater-equal: jump when xor zero
// [RL3] Nibble carry set: jump when one
// [RL4] Nibble carry clear: jump when zero
// [RL5] Copy flag set: jump when one
// [RL6] Copy flag clear: jump when zero
// [RL7] Wrap flag set: jump when one
// [RL8] Offset signed, added to PC plus one
`timescale 1ns/10ps
module cond_branch_flag_eval #(
   parameter int PC_WIDTH  = branch_pkg::PC_WIDTH_DEF,
   parameter int OFS_WIDTH = branch_pkg::OFS_WIDTH_DEF
) (
   input  wire logic                 CLK_IN,
   input  wire logic                 RST_N_IN,
   input  wire logic                 START_IN,
   input  wire branch_pkg::cond_t    COND_IN,
   input  wire logic [7:0]           FLAGS_IN,
   input  wire logic [OFS_WIDTH-1:0] OFFSET_IN,
   input  wire logic [PC_WIDTH-1:0]  PC_IN,
   output logic [PC_WIDTH-1:0]       PC_OUT,
   output logic                      PC_LOAD_OUT,
   output logic [7:0]                FLAGS_OUT,
   output logic                      BUSY_OUT,
   output logic                      DONE_OUT
);
   import branch_pkg::*;

   // Offset must fit the PC and carry a sign bit
   if (OFS_WIDTH < 2 || OFS_WIDTH > PC_WIDTH) begin : g_bad_width
      $error("OFS_WIDTH must lie in 2..PC_WIDTH");
   end

   flag_if fi ();

   state_t              state_r;
   state_t              state_nxt;
   logic [PC_WIDTH-1:0] pc_r;
   logic [PC_WIDTH-1:0] pc_nxt;
   logic                load_r;
   logic                load_nxt;
   logic                done_r;
   logic                done_nxt;
   logic [7:0]          flags_r;
   logic [7:0]          flags_nxt;

   assign fi.flags = FLAGS_IN;
   assign fi.cond  = COND_IN;

   cond_eval u_eval (
      .fi (fi.eval)
   );

   // [RL8] Sign-extended offset plus PC plus one
   function automatic logic [PC_WIDTH-1:0] target(
      input logic [PC_WIDTH-1:0]  pc,
      input logic [OFS_WIDTH-1:0] k
   );
      logic [PC_WIDTH-1:0] kx;
      kx = PC_WIDTH'($signed(k));
      return pc + kx + PC_WIDTH'(1);
   endfunction : target

   always_comb begin
      state_nxt = state_r;
      pc_nxt    = pc_r;
      load_nxt  = 1'b0;
      done_nxt  = 1'b0;
      // [RL1] Flags pass unchanged
      flags_nxt = FLAGS_IN;
      case (state_r)
         ST_IDLE: begin
            if (START_IN) begin
               if (fi.taken) begin
                  // [RL3] Taken target loaded
                  pc_nxt    = target(PC_IN, OFFSET_IN);
                  state_nxt = ST_TAKEN;
               end else begin
                  // [RL2] Fall through, one cycle
                  pc_nxt   = PC_IN + PC_WIDTH'(1);
                  load_nxt = 1'b1;
                  done_nxt = 1'b1;
               end
            end
         end
         ST_TAKEN: begin
            // [RL7] Second cycle when taken
            load_nxt  = 1'b1;
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_r <= ST_IDLE;
         pc_r    <= '0;
         load_r  <= 1'b0;
         done_r  <= 1'b0;
         flags_r <= FLAGS_RST;
      end else begin
         state_r <= state_nxt;
         pc_r    <= pc_nxt;
         load_r  <= load_nxt;
         done_r  <= done_nxt;
         flags_r <= flags_nxt;
      end
   end

   assign PC_OUT      = pc_r;
   assign PC_LOAD_OUT = load_r;
   assign FLAGS_OUT   = flags_r;
   assign DONE_OUT    = done_r;
   assign BUSY_OUT    = (state_r == ST_TAKEN);

endmodule : cond_branch_flag_eval

// file: dv/branch_sva.sv
// Branch unit port checker.
// Assumes one core clock.
`timescale 1ns/10ps
module branch_chk #(parameter int PC_WIDTH = 16, OFS_WIDTH = 7) (
   input wire logic CLK_IN, RST_N_IN, START_IN, PC_LOAD_OUT, BUSY_OUT,
   input wire logic DONE_OUT,
   input wire logic [7:0] FLAGS_IN, FLAGS_OUT,
   input wire logic [OFS_WIDTH-1:0] OFFSET_IN,
   input wire logic [PC_WIDTH-1:0] PC_IN, PC_OUT
);
   wire req = START_IN && !BUSY_OUT;
   wire [PC_WIDTH-1:0] tgt = PC_IN + PC_WIDTH'(signed'(OFFSET_IN)) + 1'b1;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence fast; PC_LOAD_OUT && !BUSY_OUT; endsequence
   sequence slow; BUSY_OUT && !PC_LOAD_OUT ##1 fast; endsequence
   a_walk_time:
      assert property (req |=> fast or slow) else $error("walk");
   a_jump_pc:
      assert property (req ##1 BUSY_OUT |-> PC_OUT == $past(tgt)) else $error("jump");
   a_skip_pc:
      assert property (req ##1 !BUSY_OUT |-> PC_OUT == $past(PC_IN) + 1'b1)
         else $error("skip");
   a_flag_copy:
      assert property (1 |=> FLAGS_OUT == $past(FLAGS_IN)) else $error("flags");
   a_done_load:
      assert property (DONE_OUT == PC_LOAD_OUT) else $error("done");
   a_busy_once:
      assert property (BUSY_OUT |=> !BUSY_OUT) else $error("busy");
   a_idle_quiet:
      assert property (!START_IN && !BUSY_OUT |=> !PC_LOAD_OUT) else $error("idle");
   a_pc_hold:
      assert property (!req |=> $stable(PC_OUT)) else $error("hold");
endmodule : branch_chk
bind cond_branch_flag_eval branch_chk #(.PC_WIDTH(PC_WIDTH),
   .OFS_WIDTH(OFS_WIDTH)) chk (.*);

// file: dv/tb.sv
// Random and corner branches into the branch unit.
// Assumes the hand-over timing.
`timescale 1ns/10ps
module tb;
   import branch_pkg::*;
   logic        clk = 0, rst_n = 0, st = 0, ld, dn, bz;
   cond_t       cd = COND_SIGNED_LESS;
   logic [7:0]  fl = 8'h00, fo;
   logic [6:0]  k = 7'h00;
   logic [15:0] pc = 16'h0000, po;
   int          n_errors = 0, n_checks = 0, seed = 32'hED4A, i;
   cond_branch_flag_eval DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .START_IN(st),
      .COND_IN(cd), .FLAGS_IN(fl), .OFFSET_IN(k), .PC_IN(pc), .PC_OUT(po),
      .PC_LOAD_OUT(ld), .FLAGS_OUT(fo), .BUSY_OUT(bz), .DONE_OUT(dn));
   initial forever #2.5 clk = ~clk;
   task check(string s, logic [15:0] a, logic [15:0] e);
      n_checks++;
      if (a !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, a);
      end
   endtask : check
   task end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   function logic tk_of(cond_t c, logic [7:0] f);
      logic n, v, h, t;
      {n, v, h, t} = {f[FLAG_SIGN_POS], f[FLAG_WRAP_POS],
         f[FLAG_NIBBLE_POS], f[FLAG_COPY_POS]};
      return 1'({v, ~t, t, ~h, h, ~(n ^ v), n ^ v} >> c);
   endfunction : tk_of
   task br(cond_t c, logic [7:0] f, logic [6:0] o, logic [15:0] p);
      logic t;
      int   n;
      t = tk_of(c, f);
      cd = c;
      {fl, k, pc, st} = {f, o, p, 1'b1};
      @(negedge clk);
      st = 0;
      for (n = 1; ld !== 1'b1; n++) begin
         if (n > 2) begin
            n_errors++;
            end_sim;
         end
         @(negedge clk);
      end
      check("cycles", 16'(n), 16'(t ? CYC_TAKEN : CYC_NOT_TAKEN));
      check("pc", po, p + (t ? 16'(signed'(o)) : 16'h0000) + 16'h0001);
      check("flags", {8'h00, fo}, {8'h00, f});
      check("done", {15'h0000, dn}, 16'h0001);
      check("busy", {15'h0000, bz}, 16'h0000);
   endtask : br
   initial begin
      repeat (10) @(negedge clk);
      check("rst_pc", po, 16'h0000);
      check("rst_ld", {15'h0000, ld}, 16'h0000);
      check("rst_busy", {15'h0000, bz}, 16'h0000);
      rst_n = 1;
      br(COND_SIGNED_WRAP_SET, 8'h08, 7'h40, 16'h0000);
      br(cond_t'(3'h7), 8'hFF, 7'h05, 16'h1234);
      br(COND_SIGNED_LESS, 8'h0C, 7'h3F, 16'hFFFF);
      for (i = 0; i < 300; i++)
         br(cond_t'(i % 7), 8'($random(seed)), 7'($random(seed)),
            16'($random(seed)));
      end_sim;
   end
endmodule : tb
